// ---- rtl/ext_irq.sv ----
// External interrupt pin: detection, flag, pull control and register port
//
// Contract
// RQ1 - Bit 4 enables pin as interrupt input; cleared, pin requests nothing.
// RQ2 - Bit 6 set turns internal pull off while pin enabled; clear keeps it.
// RQ3 - Bit 5 picks falling/low (0) or rising/high (1) sensitivity.
// RQ4 - Enabled pin pulls down for rising polarity, up for falling polarity.
// RQ5 - Bit 3 read-only flag, set on each qualifying pin event.
// RQ6 - Writing 1 to bit 2 clears flag; 0 ignored; reads 0.
// RQ7 - In edge-and-level mode acknowledge fails while pin stays asserted.
// RQ8 - Bit 1 set raises CPU interrupt whenever flag is set.
// RQ9 - Bit 0 chooses edge-only (0) or edge plus level (1) detection.
// RQ10 - Pin synchronised before edge detection; no events while disabled.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ext_irq (
	input  wire logic                 ref_clk_i,
	input  wire logic                 nrst_i,
	input  wire ext_irq_pkg::bus_req_t bus_i,
	output logic [ext_irq_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                 irq_pin_i,
	output logic                      pull_up_en_o,
	output logic                      pull_down_en_o,
	output logic                      cpu_irq_o
);
	import ext_irq_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ctrl_t             ctrl_reg;
	logic              event_flag_reg;
	logic [EV_W-1:0]   ev_status_reg;
	logic [EV_W-1:0]   ev_mask_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	pull_t             pull_reg;
	pull_t             pull_next;
	logic              irq_reg;
	logic              irq_next;
	logic              pin_level;
	logic              prev_active_reg;
	logic              pin_active;
	logic              edge_hit;
	logic              pin_event;
	logic              wr_ctrl;
	logic              wr_status;
	logic              wr_mask;
	logic              ack_write;
	logic              ack_blocked;
	logic              ack_clears;
	logic [EV_W-1:0]   ev_set;

	// ----------------------------------------------------------------
	// Pin path
	// ----------------------------------------------------------------
	// RQ10 synchronise pin
	pin_sync u_pin_sync (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.pin_i     (irq_pin_i),
		.level_o   (pin_level)
	);

	// RQ3 polarity of assertion
	assign pin_active = ctrl_reg.polarity_select ? pin_level : ~pin_level;

	// Edge is judged on the active level, so changing polarity can look
	// like an edge; software should acknowledge after reconfiguring.
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev_active_reg <= RST_BIT;
		end else begin
			prev_active_reg <= pin_active;
		end
	end

	assign edge_hit = pin_active & ~prev_active_reg;

	// RQ9 edge or edge plus level
	// RQ1 gate on pin enable
	assign pin_event = ctrl_reg.pin_function_enable
		& (edge_hit | (ctrl_reg.detect_mode & pin_active));

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	assign wr_ctrl   = bus_i.wr & (bus_i.addr == OFF_STATUS_CONTROL);
	assign wr_status = bus_i.wr & (bus_i.addr == OFF_EVENT_STATUS);
	assign wr_mask   = bus_i.wr & (bus_i.addr == OFF_EVENT_MASK);

	// RQ6 acknowledge on written one
	assign ack_write = wr_ctrl & bus_i.wdata[BIT_EVENT_ACKNOWLEDGE];

	// RQ7 level still asserted
	assign ack_blocked = ctrl_reg.detect_mode & ctrl_reg.pin_function_enable
		& pin_active;
	assign ack_clears  = ack_write & ~ack_blocked;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_reg <= '0;
		end else if (wr_ctrl) begin
			ctrl_reg.pull_device_disable <= bus_i.wdata[BIT_PULL_DISABLE];
			ctrl_reg.polarity_select     <= bus_i.wdata[BIT_POLARITY];
			ctrl_reg.pin_function_enable <= bus_i.wdata[BIT_PIN_ENABLE];
			ctrl_reg.interrupt_enable    <= bus_i.wdata[BIT_INTERRUPT_ENABLE];
			ctrl_reg.detect_mode         <= bus_i.wdata[BIT_DETECT_MODE];
		end
	end

	// ----------------------------------------------------------------
	// Event flag
	// ----------------------------------------------------------------
	// RQ5 set wins over acknowledge
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			event_flag_reg <= RST_BIT;
		end else if (pin_event) begin
			event_flag_reg <= 1'b1;
		end else if (ack_clears) begin
			event_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sticky event status and mask
	// ----------------------------------------------------------------
	always_comb begin
		ev_set                 = '0;
		ev_set[EV_PIN_EVENT]   = pin_event;
		ev_set[EV_ACK_REFUSED] = ack_write & ack_blocked;
	end

	// Per bit: write one clears, a new event wins
	genvar gi;
	generate
		for (gi = 0; gi < EV_W; gi++) begin : g_ev
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					ev_status_reg[gi] <= RST_BIT;
				end else if (ev_set[gi]) begin
					ev_status_reg[gi] <= 1'b1;
				end else if (wr_status && bus_i.wdata[gi]) begin
					ev_status_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ev_mask_reg <= RST_EV;
		end else if (wr_mask) begin
			ev_mask_reg <= bus_i.wdata[EV_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = RST_DATA;
		if (bus_i.rd) begin
			case (bus_i.addr)
				OFF_STATUS_CONTROL: begin
					rdata_next[BIT_PULL_DISABLE]     = ctrl_reg.pull_device_disable;
					rdata_next[BIT_POLARITY]         = ctrl_reg.polarity_select;
					rdata_next[BIT_PIN_ENABLE]       = ctrl_reg.pin_function_enable;
					// RQ5 flag readback
					rdata_next[BIT_EVENT_FLAG]       = event_flag_reg;
					rdata_next[BIT_INTERRUPT_ENABLE] = ctrl_reg.interrupt_enable;
					rdata_next[BIT_DETECT_MODE]      = ctrl_reg.detect_mode;
				end
				OFF_EVENT_STATUS: begin
					rdata_next[EV_W-1:0] = ev_status_reg;
				end
				OFF_EVENT_MASK: begin
					rdata_next[EV_W-1:0] = ev_mask_reg;
				end
				default: begin
					rdata_next = RST_DATA;
				end
			endcase
		end
	end

	// Data stand one cycle only, zero otherwise
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= RST_DATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// Pull device control
	// ----------------------------------------------------------------
	// RQ2 pull off when disabled bit set
	// RQ4 direction follows polarity
	always_comb begin
		pull_next = '0;
		if (ctrl_reg.pin_function_enable && !ctrl_reg.pull_device_disable) begin
			pull_next.pull_down_en = ctrl_reg.polarity_select;
			pull_next.pull_up_en   = ~ctrl_reg.polarity_select;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pull_reg <= '0;
		end else begin
			pull_reg <= pull_next;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	// RQ8 flag gated by enable
	assign irq_next = (ctrl_reg.interrupt_enable & event_flag_reg)
		| (|(ev_status_reg & ev_mask_reg));

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_reg <= RST_BIT;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign rdata_o        = rdata_reg;
	assign pull_up_en_o   = pull_reg.pull_up_en;
	assign pull_down_en_o = pull_reg.pull_down_en;
	assign cpu_irq_o      = irq_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_disabled_no_flag: assert property ( // RQ1
		!ctrl_reg.pin_function_enable && !event_flag_reg
		|=> !event_flag_reg)
		else $error("Flag set while pin function disabled");

	chk_pull_off_bit: assert property ( // RQ2
		ctrl_reg.pull_device_disable |=> !pull_up_en_o && !pull_down_en_o)
		else $error("Pull active while pull disable set");

	chk_rising_edge_flag: assert property ( // RQ3
		ctrl_reg.pin_function_enable && ctrl_reg.polarity_select
		&& $rose(pin_level) && $stable(ctrl_reg) |=> event_flag_reg)
		else $error("Rising edge did not set flag");

	chk_pull_direction: assert property ( // RQ4
		ctrl_reg.pin_function_enable && !ctrl_reg.pull_device_disable
		|=> pull_down_en_o == $past(ctrl_reg.polarity_select)
		&& pull_up_en_o != $past(ctrl_reg.polarity_select))
		else $error("Pull direction does not follow polarity");

	chk_flag_readback: assert property ( // RQ5
		bus_i.rd && bus_i.addr == OFF_STATUS_CONTROL
		|=> rdata_o[BIT_EVENT_FLAG] == $past(event_flag_reg))
		else $error("Flag readback mismatch");

	chk_ack_reads_zero: assert property ( // RQ6
		##1 $past(bus_i.rd) |-> !rdata_o[BIT_EVENT_ACKNOWLEDGE] && !rdata_o[7])
		else $error("Acknowledge bit read as one");

	chk_ack_clears: assert property ( // RQ6
		ack_write && !ack_blocked && !pin_event |=> !event_flag_reg)
		else $error("Acknowledge did not clear flag");

	chk_ack_refused: assert property ( // RQ7
		ack_write && ack_blocked |=> event_flag_reg)
		else $error("Flag cleared while level still asserted");

	chk_irq_follows: assert property ( // RQ8
		ctrl_reg.interrupt_enable && event_flag_reg |=> cpu_irq_o)
		else $error("Interrupt not raised with flag set");

	chk_edge_only: assert property ( // RQ9
		!ctrl_reg.detect_mode && $stable(pin_level) && $stable(ctrl_reg)
		|-> !pin_event)
		else $error("Level event in edge-only mode");

	chk_no_irq_idle: assert property ( // RQ8
		!irq_next ##1 !irq_next |-> !cpu_irq_o)
		else $error("Interrupt raised with no cause");

	cov_edge_event: cover property (
		ctrl_reg.pin_function_enable && edge_hit ##1 event_flag_reg);
	cov_level_refuse: cover property (ack_write && ack_blocked);
	cov_ack_clear: cover property (event_flag_reg && ack_clears ##1 !event_flag_reg);
	cov_irq_raised: cover property ($rose(cpu_irq_o));

endmodule : ext_irq

// ---- rtl/ext_irq_pkg.sv ----
// Constants and carrier types for the external interrupt pin block
package ext_irq_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS   = 8'h01;
	localparam logic [ADDR_W-1:0] OFF_EVENT_MASK     = 8'h02;

	// ----------------------------------------------------------------
	// Status/control field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_DETECT_MODE       = 0;
	localparam int unsigned BIT_INTERRUPT_ENABLE  = 1;
	localparam int unsigned BIT_EVENT_ACKNOWLEDGE = 2;
	localparam int unsigned BIT_EVENT_FLAG        = 3;
	localparam int unsigned BIT_PIN_ENABLE        = 4;
	localparam int unsigned BIT_POLARITY          = 5;
	localparam int unsigned BIT_PULL_DISABLE      = 6;

	// ----------------------------------------------------------------
	// Sticky event status positions
	// ----------------------------------------------------------------
	localparam int unsigned EV_PIN_EVENT   = 0;
	localparam int unsigned EV_ACK_REFUSED = 1;
	localparam int unsigned EV_W           = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_DATA  = 8'h00;
	localparam logic [EV_W-1:0]   RST_EV    = 2'h0;
	localparam logic              RST_BIT   = 1'b0;
	localparam logic [1:0]        RST_SYNC  = 2'h0;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	typedef struct packed {
		logic pull_device_disable;
		logic polarity_select;
		logic pin_function_enable;
		logic interrupt_enable;
		logic detect_mode;
	} ctrl_t;

	typedef struct packed {
		logic pull_up_en;
		logic pull_down_en;
	} pull_t;

endpackage : ext_irq_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for the asynchronous interrupt pin
`timescale 1ns/1ps
module pin_sync (
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	import ext_irq_pkg::*;

	logic [1:0] sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_reg <= RST_SYNC;
		end else begin
			sync_reg <= {sync_reg[0], pin_i};
		end
	end

	assign level_o = sync_reg[1];

endmodule : pin_sync

// ---- bench/pin_device.sv ----
// External device model that drives the interrupt pin or leaves it to the pulls
`timescale 1ns/1ps
module pin_device (
	input  wire logic ref_clk_i,
	input  wire logic drive_en_i,
	input  wire logic drive_val_i,
	input  wire logic pull_up_en_i,
	input  wire logic pull_down_en_i,
	output logic      pin_o
);
	initial pin_o = 1'b1;
	// A floating pin toggles every cycle, so a missing pull cannot pass by chance
	always @(posedge ref_clk_i) begin
		if (drive_en_i)
			pin_o <= drive_val_i;
		else if (pull_up_en_i)
			pin_o <= 1'b1;
		else if (pull_down_en_i)
			pin_o <= 1'b0;
		else
			pin_o <= ~pin_o;
	end
endmodule : pin_device

// ---- bench/tb_top.sv ----
// Self-checking bench for the external interrupt pin block
`timescale 1ns/1ps
module tb_top;
	import ext_irq_pkg::*;
	logic     ref_clk_i = 1'b0;
	logic     nrst_i    = 1'b0;
	logic     drv_en    = 1'b1;
	logic     drv_val   = 1'b1;
	logic     pin, pu, pd, irq;
	logic [7:0] rdata;
	bus_req_t bus_i     = '0;
	int       error_cnt = 0;
	int       checked   = 0;
	int       m_ctrl = 0, m_flag = 0, m_stat = 0, m_mask = 0, m_pin = 1;

	always #4 ref_clk_i = ~ref_clk_i;

	ext_irq u_ext_irq (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata),
		.irq_pin_i(pin), .pull_up_en_o(pu), .pull_down_en_o(pd), .cpu_irq_o(irq));
	pin_device u_pin_device (.ref_clk_i(ref_clk_i), .drive_en_i(drv_en), .drive_val_i(drv_val),
		.pull_up_en_i(pu), .pull_down_en_i(pd), .pin_o(pin));

	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	task automatic chk_pins();
		logic [2:0] e;
		repeat (2) @(posedge ref_clk_i);
		#1;
		e[2] = m_ctrl[4] & !m_ctrl[6] & !m_ctrl[5];
		e[1] = m_ctrl[4] & !m_ctrl[6] & m_ctrl[5];
		e[0] = (m_ctrl[1] & m_flag[0]) | (|(m_stat & m_mask));
		checked++;
		if ({pu, pd, irq} !== e) begin
			error_cnt++;
			$display("wrong value pins expected %b seen %b", e, {pu, pd, irq});
		end
	endtask : chk_pins

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_i) bus_i <= '0;
		if (a == OFF_STATUS_CONTROL) begin
			// The acknowledge is judged against the settings held before this write
			if (d[2] && m_ctrl[0] && m_ctrl[4] && m_pin == m_ctrl[5])
				m_stat |= 2;
			else if (d[2])
				m_flag = 0;
			m_ctrl = d & 8'h73;
		end else if (a == OFF_EVENT_STATUS)
			m_stat &= ~d;
		else if (a == OFF_EVENT_MASK)
			m_mask = d & 3;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] msk);
		@(posedge ref_clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk_i) bus_i <= '0;
		#1;
		chk_reg("rdata", e & msk, rdata & msk);
	endtask : rd

	task automatic pin_set(int v);
		@(posedge ref_clk_i) drv_val <= v[0];
		repeat (6) @(posedge ref_clk_i);
		if (m_ctrl[4] && v == m_ctrl[5] && (m_pin != m_ctrl[5] || m_ctrl[0])) begin
			m_flag = 1;
			m_stat |= 1;
		end
		m_pin = v;
	endtask : pin_set

	function automatic logic [7:0] ctrl_rd();
		return 8'(m_ctrl | (m_flag << 3));
	endfunction : ctrl_rd

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		error_cnt++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(28050));
		repeat (4) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rd(OFF_STATUS_CONTROL, 8'h00, 8'hff);
		rd(OFF_EVENT_STATUS, 8'h00, 8'hff);
		rd(8'h05, 8'h00, 8'hff);
		chk_pins();
		$display("test reset done");
		drv_en <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			wr(OFF_STATUS_CONTROL, 8'($urandom) & 8'hfd);
			rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hf7);
			chk_pins();
		end
		wr(OFF_STATUS_CONTROL, 8'h00);
		drv_en <= 1'b1;
		pin_set(1);
		wr(OFF_STATUS_CONTROL, 8'h04);
		wr(OFF_EVENT_STATUS, 8'h03);
		rd(OFF_EVENT_STATUS, 8'(m_stat), 8'hff);
		$display("test pull control done");
		wr(OFF_STATUS_CONTROL, 8'h12);
		chk_pins();
		pin_set(0);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		chk_pins();
		wr(OFF_STATUS_CONTROL, 8'h12);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		wr(OFF_STATUS_CONTROL, 8'h16);
		chk_pins();
		pin_set(1);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		$display("test falling edge done");
		wr(OFF_STATUS_CONTROL, 8'h10);
		pin_set(0);
		chk_pins();
		rd(OFF_EVENT_STATUS, 8'(m_stat), 8'hff);
		wr(OFF_EVENT_MASK, 8'h01);
		rd(OFF_EVENT_MASK, 8'(m_mask), 8'hff);
		chk_pins();
		wr(OFF_EVENT_STATUS, 8'h01);
		chk_pins();
		wr(OFF_STATUS_CONTROL, 8'h14);
		$display("test polling done");
		wr(OFF_STATUS_CONTROL, 8'h02);
		pin_set(1);
		pin_set(0);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		chk_pins();
		$display("test disabled pin done");
		wr(OFF_STATUS_CONTROL, 8'h33);
		pin_set(1);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		wr(OFF_STATUS_CONTROL, 8'h37);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		rd(OFF_EVENT_STATUS, 8'(m_stat), 8'hff);
		pin_set(0);
		wr(OFF_STATUS_CONTROL, 8'h37);
		rd(OFF_STATUS_CONTROL, ctrl_rd(), 8'hff);
		chk_pins();
		$display("test level mode done");
		close_out();
	end
endmodule : tb_top
